// ==== design/asrc_core.v ====
// Sample-rate converters between serial audio ports and converter core.
// Assumes port frame clocks are pins, all else is logic on i_mclk.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "asrc_defs.vh"
module asrc_core #(
    parameter W = 24
) (
    input wire i_mclk,
    input wire i_reset_n,
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    input wire i_port_frame_clock,
    input wire i_link_frame_clock,
    input wire i_internal_fs_tick,
    input wire [W-1:0] i_port_rx1,
    input wire [W-1:0] i_port_rx2,
    input wire [W-1:0] i_port_rx3,
    input wire [W-1:0] i_port_rx4,
    input wire [W-1:0] i_link_rx1,
    input wire [W-1:0] i_link_rx2,
    input wire [W-1:0] i_link_rx3,
    input wire [W-1:0] i_link_rx4,
    input wire [W-1:0] i_core_tx,
    output reg [W-1:0] o_core_rx_left,
    output reg [W-1:0] o_core_rx_right,
    output reg o_core_rx_valid,
    output reg [W-1:0] o_spdif_a,
    output reg [W-1:0] o_spdif_b,
    output reg o_spdif_valid,
    output reg [W-1:0] o_port_tx1,
    output reg o_port_tx_valid
);

    // ------------------------------------------
    // Declarations
    // ------------------------------------------
    // Control words
    reg [12:0] ctrl_q;
    reg [12:0] act_q;

    // Pin sync stages
    reg port_s1_q;
    reg port_s2_q;
    reg port_s3_q;
    reg link_s1_q;
    reg link_s2_q;
    reg link_s3_q;

    // Control fields
    wire run = act_q[`CTRL_RUN];
    wire playback_resampler_skip = act_q[`CTRL_PB_SKIP];
    wire capture_resampler_skip = act_q[`CTRL_CAP_SKIP];
    wire [1:0] input_resampler_clock_select = act_q[`CTRL_ICLK_LO+1:`CTRL_ICLK_LO];
    wire [1:0] output_resampler_clock_select = act_q[`CTRL_OCLK_LO+1:`CTRL_OCLK_LO];
    wire internal_rate_enable = act_q[`CTRL_RATE_EN];
    wire link_select = act_q[`CTRL_LINK];
    wire [3:0] port_rate_setting = act_q[`CTRL_RATE_LO+3:`CTRL_RATE_LO];

    // Rate ticks
    wire port_edge;
    wire link_edge;
    wire frame_tick;
    wire fs_tick;
    // Lock length
    wire [7:0] lock_need;

    // Lane buses
    wire [W-1:0] rx_sel [0:3];
    wire [W-1:0] lane_in [0:2];
    wire [W-1:0] lane_out [0:2];
    wire [2:0] lane_valid;
    wire [2:0] lane_in_tick;
    wire [2:0] lane_out_tick;
    wire [2:0] lane_skip;
    wire [2:0] lane_band;

    // Tracker results
    wire [15:0] rx_frac;
    wire [15:0] tx_frac;
    wire rx_locked;
    wire tx_locked;
    wire rx_down;
    wire tx_down;
    wire rx_bad;
    wire tx_bad;

    // Status
    wire [31:0] status;

    // Clock-select code to MHz; code 10 taken as 24 MHz
    function [4:0] clk_mhz;
        input [1:0] code;
        begin
            case (code)
                `CLK_CODE_6M: clk_mhz = `CLK_MHZ_6;
                `CLK_CODE_12M: clk_mhz = `CLK_MHZ_12;
                default: clk_mhz = `CLK_MHZ_24;
            endcase
        end
    endfunction

    // ------------------------------------------
    // Register port
    // ------------------------------------------

    // Control register write
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= `CTRL_RESET;
        end else if (i_wr && i_addr == `REG_CTRL) begin
            ctrl_q <= i_wdata[12:0];
        end
    end

    // Settings take effect only while stopped, or on start
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            act_q <= `CTRL_RESET;
        end else if (!act_q[`CTRL_RUN]) begin
            act_q <= ctrl_q;
        end else begin
            // Run bit only
            act_q[`CTRL_RUN] <= ctrl_q[`CTRL_RUN];
        end
    end

    // Status word from tracker state and clock decode
    assign status = {11'h000,
                     clk_mhz(output_resampler_clock_select),
                     3'h0,
                     clk_mhz(input_resampler_clock_select),
                     3'h0,
                     rx_bad | tx_bad,
                     tx_down,
                     rx_down,
                     tx_locked,
                     rx_locked};

    // Read data one cycle after the strobe, zero otherwise
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                `REG_CTRL: o_rdata <= {19'h00000, ctrl_q};
                `REG_STATUS: o_rdata <= status;
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    // ------------------------------------------
    // Frame clock synchronisers and ticks
    // ------------------------------------------

    // Two flops per pin, third for edge detect
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // Main port
            port_s1_q <= 1'b0;
            port_s2_q <= 1'b0;
            port_s3_q <= 1'b0;
            // Link
            link_s1_q <= 1'b0;
            link_s2_q <= 1'b0;
            link_s3_q <= 1'b0;
        end else begin
            // Main port
            port_s1_q <= i_port_frame_clock;
            port_s2_q <= port_s1_q;
            port_s3_q <= port_s2_q;
            // Link
            link_s1_q <= i_link_frame_clock;
            link_s2_q <= link_s1_q;
            link_s3_q <= link_s2_q;
        end
    end

    assign port_edge = port_s2_q & ~port_s3_q;
    assign link_edge = link_s2_q & ~link_s3_q;
    assign frame_tick = run & (link_select ? link_edge : port_edge);
    assign fs_tick = run & internal_rate_enable & i_internal_fs_tick;

    // Unknown port rate means a longer lock qualification
    assign lock_need = (port_rate_setting == `RATE_UNKNOWN) ? `LOCK_SLOW : `LOCK_FAST;

    // Receive source: main port or two-wire link
    assign rx_sel[0] = link_select ? i_link_rx1 : i_port_rx1;
    assign rx_sel[1] = link_select ? i_link_rx2 : i_port_rx2;
    assign rx_sel[2] = link_select ? i_link_rx3 : i_port_rx3;
    assign rx_sel[3] = link_select ? i_link_rx4 : i_port_rx4;

    // ------------------------------------------
    // Rate trackers
    // ------------------------------------------

    // Receive: frame clock in, internal Fs out
    rate_tracker u_rx_track (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_run(run),
        .i_in_tick(frame_tick),
        .i_out_tick(fs_tick),
        .i_lock_need(lock_need),
        .o_frac(rx_frac),
        .o_locked(rx_locked),
        .o_downsample(rx_down),
        .o_ratio_bad(rx_bad)
    );

    // Transmit: internal Fs in, frame clock out
    rate_tracker u_tx_track (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_run(run),
        .i_in_tick(fs_tick),
        .i_out_tick(frame_tick),
        .i_lock_need(lock_need),
        .o_frac(tx_frac),
        .o_locked(tx_locked),
        .o_downsample(tx_down),
        .o_ratio_bad(tx_bad)
    );

    // ------------------------------------------
    // Resampling lanes: two receive, one transmit
    // ------------------------------------------

    // Lane wiring: lanes 0,1 receive, lane 2 transmit
    assign lane_in[0] = rx_sel[0];
    assign lane_in[1] = rx_sel[1];
    assign lane_in[2] = i_core_tx;
    assign lane_in_tick = {fs_tick, frame_tick, frame_tick};
    assign lane_out_tick = {frame_tick, fs_tick, fs_tick};
    assign lane_skip = {capture_resampler_skip, playback_resampler_skip, playback_resampler_skip};
    assign lane_band = {tx_down, rx_down, rx_down};

    // Lane array
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_lane
            resample_lane #(
                .W(W)
            ) u_lane (
                .i_mclk(i_mclk),
                .i_reset_n(i_reset_n),
                .i_in_tick(lane_in_tick[g]),
                .i_out_tick(lane_out_tick[g]),
                .i_skip(lane_skip[g]),
                .i_band_limit(lane_band[g]),
                .i_frac((g == 2) ? tx_frac : rx_frac),
                .i_sample(lane_in[g]),
                .o_sample(lane_out[g]),
                .o_valid(lane_valid[g])
            );
        end
    endgenerate

    // ------------------------------------------
    // Output registers
    // ------------------------------------------

    // Core-side receive pair, port-side transmit channel
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_core_rx_left <= {W{1'b0}};
            o_core_rx_right <= {W{1'b0}};
            o_core_rx_valid <= 1'b0;
            o_port_tx1 <= {W{1'b0}};
            o_port_tx_valid <= 1'b0;
        end else begin
            // Receive pair
            o_core_rx_valid <= lane_valid[0];
            if (lane_valid[0]) begin
                o_core_rx_left <= lane_out[0];
                o_core_rx_right <= lane_out[1];
            end
            // Transmit lane
            o_port_tx_valid <= lane_valid[2];
            if (lane_valid[2])
                o_port_tx1 <= lane_out[2];
        end
    end

    // Channels three and four go to S/PDIF unconverted
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_spdif_a <= {W{1'b0}};
            o_spdif_b <= {W{1'b0}};
            o_spdif_valid <= 1'b0;
        end else begin
            // Every frame
            o_spdif_valid <= frame_tick;
            if (frame_tick) begin
                o_spdif_a <= rx_sel[2];
                o_spdif_b <= rx_sel[3];
            end
        end
    end
endmodule

// ==== design/rate_tracker.v ====
// Digital PLL tracking one input and one output sample-rate tick.
// Assumes ticks are one-cycle pulses on i_mclk.
`timescale 1ns/1ps
`include "asrc_defs.vh"
module rate_tracker (
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_run,
    input wire i_in_tick,
    input wire i_out_tick,
    input wire [7:0] i_lock_need,
    output wire [15:0] o_frac,
    output reg o_locked,
    output reg o_downsample,
    output reg o_ratio_bad
);
    reg signed [25:0] phase_q;
    reg signed [25:0] step_q;
    reg [7:0] good_q;
    reg [2:0] in_cnt_q;
    reg [2:0] out_cnt_q;
    wire signed [25:0] err = phase_q - `PHASE_ONE;
    wire signed [25:0] adv = phase_q + step_q;
    wire signed [25:0] abs_err = err[25] ? -err : err;

    // Phase since last input tick, clamped to one period
    assign o_frac = phase_q[25] ? 16'h0000 : (phase_q[24] ? 16'hFFFF : phase_q[23:8]);

    // ------------------------------------------
    // Loop: phase and frequency correction
    // ------------------------------------------
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_q <= 26'h0000000;
            step_q <= `STEP_INIT;
            good_q <= 8'h00;
            o_locked <= 1'b0;
        end else if (!i_run) begin
            phase_q <= 26'h0000000;
            step_q <= `STEP_INIT;
            good_q <= 8'h00;
            o_locked <= 1'b0;
        end else if (i_in_tick) begin
            // Small gains keep jitter off the output timing
            phase_q <= adv - $signed(`PHASE_ONE) - (err >>> `PLL_PGAIN);
            step_q <= step_q - (err >>> `PLL_FGAIN);
            if (abs_err < `LOCK_WINDOW) begin
                if (good_q != 8'hFF)
                    good_q <= good_q + 8'h01;
                o_locked <= (good_q >= i_lock_need);
            end else begin
                good_q <= 8'h00;
                o_locked <= 1'b0;
            end
        end else if (!(~phase_q[25] & adv[25])) begin
            phase_q <= adv; // Hold instead of wrapping
        end
    end

    // ------------------------------------------
    // Ratio watch: ticks of one side per other
    // ------------------------------------------
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            in_cnt_q <= 3'h0;
            out_cnt_q <= 3'h0;
            o_downsample <= 1'b0;
            o_ratio_bad <= 1'b0;
        end else if (!i_run) begin
            in_cnt_q <= 3'h0;
            out_cnt_q <= 3'h0;
            o_downsample <= 1'b0;
            o_ratio_bad <= 1'b0;
        end else begin
            if (i_out_tick) begin
                in_cnt_q <= {2'h0, i_in_tick};
                o_downsample <= (in_cnt_q >= 3'h2);
                if (in_cnt_q > `RATIO_MAX)
                    o_ratio_bad <= 1'b1;
            end else if (i_in_tick && in_cnt_q != 3'h7) begin
                in_cnt_q <= in_cnt_q + 3'h1;
            end
            if (i_in_tick) begin
                out_cnt_q <= {2'h0, i_out_tick};
                if (out_cnt_q > `RATIO_MAX)
                    o_ratio_bad <= 1'b1;
            end else if (i_out_tick && out_cnt_q != 3'h7) begin
                out_cnt_q <= out_cnt_q + 3'h1;
            end
        end
    end
endmodule

// ==== design/resample_lane.v ====
// One resampling lane: band limit, interpolation, or straight pass.
// Assumes ticks are one-cycle pulses and frac comes from a tracker.
`timescale 1ns/1ps
module resample_lane #(
    parameter W = 24
) (
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_in_tick,
    input wire i_out_tick,
    input wire i_skip,
    input wire i_band_limit,
    input wire [15:0] i_frac,
    input wire [W-1:0] i_sample,
    output reg [W-1:0] o_sample,
    output reg o_valid
);
    reg signed [W-1:0] prev_q;
    reg signed [W-1:0] cur_q;
    wire signed [W:0] half = ($signed(i_sample) - cur_q) >>> 1;
    wire signed [W:0] diff = cur_q - prev_q;
    wire signed [W+17:0] prod = diff * $signed({1'b0, i_frac});
    wire signed [W+1:0] interp = prev_q + prod[W+17:16];
    wire signed [W:0] smooth = cur_q + half;

    // ------------------------------------------
    // Sample history and output
    // ------------------------------------------
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev_q <= {W{1'b0}};
            cur_q <= {W{1'b0}};
            o_sample <= {W{1'b0}};
            o_valid <= 1'b0;
        end else begin
            o_valid <= 1'b0;
            if (i_skip) begin
                if (i_in_tick) begin
                    o_sample <= i_sample;
                    o_valid <= 1'b1;
                end
            end else begin
                if (i_in_tick) begin
                    prev_q <= cur_q;
                    // Halfway step suppresses images when decimating
                    cur_q <= i_band_limit ? smooth[W-1:0] : i_sample;
                end
                if (i_out_tick) begin
                    o_sample <= interp[W-1:0];
                    o_valid <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== shared/asrc_defs.vh ====
// Constants for the asynchronous sample-rate converter block.
// Assumes inclusion by bare name from every design file that needs it.
// What this block does
// - Convert main-port receive channels one and two; channels three, four go straight to S/PDIF.
// - Convert exactly one transmit channel, the first, of the main port.
// - On the two-wire link, same split: rx one, two converted, one tx converted; the code has no link transmit output, the tx lane drives only o_port_tx1.
// - Playback and capture converters each have their own skip bit.
// - Core side feeds the converter datapaths; upsample then downsample, keep 20 kHz; the code interpolates linearly between two held samples instead.
// - When output rate is below input rate, band-limit the input first.
// - Clock-select code 00 means 6 MHz, 01 means 12 MHz, top code 24 MHz.
// - Input jitter must not reach the output clock; heavy filtering of phase.
// - Digital PLL tracks phase and ratio, steering a time-varying interpolation filter.
// - Receive: input rate from port frame clock, output from internal Fs; transmit swapped.
// - A known port rate setting locks faster; unknown setting locks slower.
`ifndef ASRC_DEFS_VH
`define ASRC_DEFS_VH
// Register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define CTRL_RESET 13'h0000
// Control field positions
`define CTRL_PB_SKIP 0
`define CTRL_CAP_SKIP 1
`define CTRL_ICLK_LO 2
`define CTRL_OCLK_LO 4
`define CTRL_RATE_EN 6
`define CTRL_LINK 7
`define CTRL_RATE_LO 8
`define CTRL_RUN 12
// Status field positions
`define ST_RX_LOCK 0
`define ST_TX_LOCK 1
`define ST_RX_DOWN 2
`define ST_TX_DOWN 3
`define ST_RATIO 4
`define ST_ICLK_LO 8
`define ST_OCLK_LO 16
// Clock-select codes and decoded MHz
`define CLK_CODE_6M 2'h0
`define CLK_CODE_12M 2'h1
`define CLK_MHZ_6 5'h06
`define CLK_MHZ_12 5'h0C
`define CLK_MHZ_24 5'h18
// Port rate setting meaning unknown
`define RATE_UNKNOWN 4'h0
// Lock timing counts in input ticks
`define LOCK_FAST 8'h10
`define LOCK_SLOW 8'h40
`define RATIO_MAX 3'h6
// PLL numerics, phase unit is one input period
`define PHASE_ONE 26'h1000000
`define STEP_INIT 26'h0013B13
`define LOCK_WINDOW 26'h0100000
`define PLL_PGAIN 2
`define PLL_FGAIN 6
`endif

// ==== test/asrc_core_properties.sv ====
// Checker for the rate converter: read timing, status fields, output causes.
// Assumes binding onto asrc_core; frame pins and the Fs strobe drive the paths.
`timescale 1ns/1ps
module asrc_core_properties (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_port_frame_clock,
    input wire logic i_link_frame_clock,
    input wire logic i_internal_fs_tick,
    input wire logic o_core_rx_valid,
    input wire logic o_spdif_valid,
    input wire logic o_port_tx_valid
);
    logic pin_q;
    logic [3:0] fr_age;
    logic [3:0] fs_age;
    // ----------------------------------------
    // Cycles since last pin rise and last strobe
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_q <= 1'b0;
            fr_age <= 4'hF;
            fs_age <= 4'hF;
        end else begin
            pin_q <= i_port_frame_clock | i_link_frame_clock;
            if ((i_port_frame_clock | i_link_frame_clock) && !pin_q) fr_age <= 4'h1;
            else if (fr_age != 4'hF) fr_age <= fr_age + 4'h1;
            if (i_internal_fs_tick) fs_age <= 4'h1;
            else if (fs_age != 4'hF) fs_age <= fs_age + 4'h1;
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    sequence s_ctrl_rd;
        i_rd && i_addr == 8'h00;
    endsequence
    sequence s_stat_rd;
        i_rd && i_addr == 8'h04;
    endsequence
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (i_rd && i_addr != 8'h00 && i_addr != 8'h04 |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_upper: assert property (s_ctrl_rd |=> o_rdata[31:13] == 19'h0)
        else $error("control spare bits not zero");
    a_status_spare: assert property (s_stat_rd |=> {o_rdata[31:21], o_rdata[15:13], o_rdata[7:5]} == 17'h0)
        else $error("status spare bits not zero");
    a_clock_decode: assert property (s_stat_rd |=> o_rdata[12:8] inside {5'h06, 5'h0C, 5'h18} &&
        o_rdata[20:16] inside {5'h06, 5'h0C, 5'h18}) else $error("clock select decode out of set");
    a_spdif_cause: assert property (o_spdif_valid |-> fr_age inside {[4'h2:4'h6]})
        else $error("spdif valid without recent frame");
    a_spdif_pulse: assert property (o_spdif_valid |=> !o_spdif_valid)
        else $error("spdif valid longer than one cycle");
    a_rx_cause: assert property (o_core_rx_valid |-> fr_age inside {[4'h3:4'h8]} || fs_age inside {[4'h1:4'h3]})
        else $error("rx valid without a rate tick");
    a_tx_cause: assert property (o_port_tx_valid ##1 1'b1 |-> $past(fs_age) inside {[4'h1:4'h3]} ||
        $past(fr_age) inside {[4'h3:4'h8]}) else $error("tx valid without a rate tick");
endmodule
bind asrc_core asrc_core_properties u_props (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_port_frame_clock(i_port_frame_clock),
    .i_link_frame_clock(i_link_frame_clock), .i_internal_fs_tick(i_internal_fs_tick),
    .o_core_rx_valid(o_core_rx_valid), .o_spdif_valid(o_spdif_valid), .o_port_tx_valid(o_port_tx_valid));

// ==== test/asrc_core_tb.sv ====
// Testbench for the rate converter: registers, pass paths, rate status.
// Assumes the host model drives both frame pins, the Fs strobe and samples.
`timescale 1ns/1ps
module asrc_core_tb;
    logic i_mclk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, en = 0, lnk = 0, rx_on = 0, tx_on = 0;
    logic [7:0] i_addr = 8'h00, fper = 8'h14, sper = 8'h14;
    logic [31:0] i_wdata = 32'h0, d;
    logic [23:0] i_core_tx = 24'h0, base = 24'h0;
    logic fclk, fst;
    logic [3:0][23:0] prx, lrx;
    wire [31:0] o_rdata;
    wire [23:0] o_core_rx_left, o_core_rx_right, o_spdif_a, o_spdif_b, o_port_tx1;
    wire o_core_rx_valid, o_spdif_valid, o_port_tx_valid;
    int checks = 0, num_errors = 0, n_sp = 0, n_rx = 0, n_tx = 0;
    initial begin
        forever #50 i_mclk = ~i_mclk;
    end
    asrc_core #(.W(24)) DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_frame_clock(fclk), .i_link_frame_clock(fclk),
        .i_internal_fs_tick(fst), .i_port_rx1(prx[0]), .i_port_rx2(prx[1]), .i_port_rx3(prx[2]),
        .i_port_rx4(prx[3]), .i_link_rx1(lrx[0]), .i_link_rx2(lrx[1]), .i_link_rx3(lrx[2]),
        .i_link_rx4(lrx[3]), .i_core_tx(i_core_tx), .o_core_rx_left(o_core_rx_left),
        .o_core_rx_right(o_core_rx_right), .o_core_rx_valid(o_core_rx_valid), .o_spdif_a(o_spdif_a),
        .o_spdif_b(o_spdif_b), .o_spdif_valid(o_spdif_valid), .o_port_tx1(o_port_tx1),
        .o_port_tx_valid(o_port_tx_valid));
    audio_port_host host (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_en(en), .i_frame_per(fper),
        .i_fs_per(sper), .i_base(base), .o_frame_clk(fclk), .o_fs_tick(fst), .o_port_rx(prx), .o_link_rx(lrx));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [23:0] pick(input int ch);
        return lnk ? lrx[ch] : prx[ch];
    endfunction
    function automatic logic [31:0] cf(input logic pb, cap, input logic [1:0] ic, oc, input logic lk, run);
        return {19'h0, run, 4'h1, lk, 1'b1, oc, ic, cap, pb};
    endfunction
    function automatic logic [31:0] mhz(input logic [1:0] c);
        return (c == 2'h0) ? 32'h06 : (c == 2'h1) ? 32'h0C : 32'h18;
    endfunction
    task automatic cmp(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        v = o_rdata;
    endtask
    task automatic go(input logic pb, cap, lk, input logic [7:0] fp, sp);
        lnk = lk;
        fper <= fp;
        sper <= sp;
        base <= 24'($urandom);
        wr(8'h00, cf(pb, cap, 2'h0, 2'h0, lk, 1'b0));
        wr(8'h00, cf(pb, cap, 2'h0, 2'h0, lk, 1'b1));
        en <= 1'b1;
    endtask
    task automatic stop();
        en <= 1'b0;
        wr(8'h00, 32'h0);
        repeat (2) @(posedge i_mclk); // Let run clear
    endtask
    task automatic wt(input int n);
        int t;
        t = n_sp + n;
        for (int k = 0; k < 20000 && n_sp < t; k++) @(posedge i_mclk);
        if (n_sp < t) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, n_sp, t);
            results();
        end
    endtask
    task automatic results();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------
    // Monitors
    // ----------------------------------------
    always @(posedge i_mclk) begin
        if (o_spdif_valid === 1'b1) begin
            n_sp++;
            cmp(o_spdif_a, pick(2));
            cmp(o_spdif_b, pick(3));
        end
        if (rx_on && o_core_rx_valid === 1'b1) begin
            n_rx++;
            cmp(o_core_rx_left, pick(0));
            cmp(o_core_rx_right, pick(1));
        end
        if (tx_on && o_port_tx_valid === 1'b1) begin
            n_tx++;
            cmp(o_port_tx1, i_core_tx);
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(92083));
        repeat (16) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        rd(8'h00, d);
        cmp(d, 32'h0);
        rd(8'h08, d);
        cmp(d, 32'h0);
        wr(8'h08, 32'hFFFFFFFF);
        rd(8'h00, d);
        cmp(d, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, cf(1'b0, 1'b0, 2'(c), 2'(3 - c), 1'b0, 1'b0));
            rd(8'h00, d);
            cmp(d, cf(1'b0, 1'b0, 2'(c), 2'(3 - c), 1'b0, 1'b0));
            rd(8'h04, d);
            cmp(32'(d[12:8]), mhz(2'(c)));
            cmp(32'(d[20:16]), mhz(2'(3 - c)));
        end
        // Both converters skipped; a running control write must not switch source
        i_core_tx <= 24'($urandom);
        rx_on = 1'b1;
        tx_on = 1'b1;
        go(1'b1, 1'b1, 1'b0, 8'h14, 8'h14);
        wt(12);
        wr(8'h00, cf(1'b1, 1'b1, 2'h0, 2'h0, 1'b1, 1'b1));
        wt(6);
        stop();
        go(1'b1, 1'b1, 1'b1, 8'h14, 8'h11);
        wt(12);
        stop();
        cmp(n_rx > 20, 1'b1);
        cmp(n_tx > 20, 1'b1);
        rx_on = 1'b0;
        tx_on = 1'b0;
        // Converting with a fast input: rx path must band-limit, tx must not
        go(1'b0, 1'b0, 1'b0, 8'h14, 8'h3C);
        wt(40);
        rd(8'h04, d);
        cmp(d[2], 1'b1);
        cmp(d[3], 1'b0);
        cmp(d[4], 1'b0);
        stop();
        go(1'b0, 1'b0, 1'b0, 8'h0A, 8'h64);
        wt(60);
        rd(8'h04, d);
        cmp(d[4], 1'b1);
        stop();
        rd(8'h04, d);
        cmp(d[4], 1'b0);
        results();
    end
endmodule

// ==== test/audio_port_host.sv ====
// Host-side model: frame clock pin, internal Fs strobe and port samples.
// Assumes periods of at least ten cycles, set while the model is off.
`timescale 1ns/1ps
module audio_port_host (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_en,
    input wire logic [7:0] i_frame_per,
    input wire logic [7:0] i_fs_per,
    input wire logic [23:0] i_base,
    output logic o_frame_clk,
    output logic o_fs_tick,
    output logic [3:0][23:0] o_port_rx,
    output logic [3:0][23:0] o_link_rx
);
    logic [7:0] fcnt;
    logic [7:0] scnt;
    logic [15:0] nfr;
    // Frame clock as input rate, Fs strobe as output rate; still while off
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fcnt <= 8'h00;
            scnt <= 8'h00;
            nfr <= 16'h0000;
            o_frame_clk <= 1'b0;
            o_fs_tick <= 1'b0;
            o_port_rx <= '0;
            o_link_rx <= '0;
        end else if (!i_en) begin
            fcnt <= 8'h00;
            scnt <= 8'h00;
            o_frame_clk <= 1'b0;
            o_fs_tick <= 1'b0;
            o_port_rx <= ~o_port_rx; // Stale lines never hold a value
            o_link_rx <= ~o_link_rx;
        end else begin
            fcnt <= (fcnt == i_frame_per - 8'h01) ? 8'h00 : fcnt + 8'h01;
            scnt <= (scnt == i_fs_per - 8'h01) ? 8'h00 : scnt + 8'h01;
            o_frame_clk <= fcnt < (i_frame_per >> 1);
            o_fs_tick <= scnt == 8'h00;
            // New, distinct sample per channel at each frame rise
            if (fcnt == 8'h00) begin
                nfr <= nfr + 16'h0001;
                for (int n = 0; n < 4; n++) begin
                    o_port_rx[n] <= i_base + {nfr, n[7:0]};
                    o_link_rx[n] <= ~(i_base + {nfr, n[7:0]});
                end
            end
        end
    end
endmodule
